/* inc/rpoc_cfg.svh */
// Purpose: offsets, reset values, field positions and timing counts of the reverse power control
// Assumes: 25 MHz core clock
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef RPOC_CFG_SVH
`define RPOC_CFG_SVH

`define RPOC_CLK_HZ              25000000
`define RPOC_CYC_PER_MS          (`RPOC_CLK_HZ / 1000)

// register offsets
`define RPOC_OFS_CTRL_ONE        8'h0e
`define RPOC_OFS_CTRL_TWO        8'h0f

// reset values and writable masks
`define RPOC_RST_CTRL_ONE        8'had
`define RPOC_RST_CTRL_TWO        8'h43
`define RPOC_MASK_CTRL_ONE       8'hef
`define RPOC_RST_PIN_SYNC        3'h7
`define RPOC_RST_PIN_LEVEL       1'b1

// control one fields
`define RPOC_B_MASTER_ALLOW      7
`define RPOC_B_PIN_BYPASS        6
`define RPOC_B_SOFTSTART         5
`define RPOC_B_SHUTOFF_HI        3
`define RPOC_B_SHUTOFF_LO        2
`define RPOC_B_PIN_POLARITY      1
`define RPOC_B_SHUTOFF_EN        0

// control two fields
`define RPOC_B_CUTOFF_HI         7
`define RPOC_B_CUTOFF_LO         5
`define RPOC_B_STATUS_IND        4
`define RPOC_B_CABLE_HI          3
`define RPOC_B_CABLE_LO          2
`define RPOC_B_START_DLY_HI      1
`define RPOC_B_START_DLY_LO      0

// times in milliseconds
`define RPOC_START_DLY_A_MS      200
`define RPOC_START_DLY_B_MS      500
`define RPOC_START_DLY_C_MS      1000
`define RPOC_SHUTOFF_A_MS        10000
`define RPOC_SHUTOFF_B_MS        20000
`define RPOC_SHUTOFF_C_MS        30000

// cycle counts
`define RPOC_START_DLY_A_CYC     (`RPOC_START_DLY_A_MS * `RPOC_CYC_PER_MS)
`define RPOC_START_DLY_B_CYC     (`RPOC_START_DLY_B_MS * `RPOC_CYC_PER_MS)
`define RPOC_START_DLY_C_CYC     (`RPOC_START_DLY_C_MS * `RPOC_CYC_PER_MS)
`define RPOC_SHUTOFF_A_CYC       (`RPOC_SHUTOFF_A_MS * `RPOC_CYC_PER_MS)
`define RPOC_SHUTOFF_B_CYC       (`RPOC_SHUTOFF_B_MS * `RPOC_CYC_PER_MS)
`define RPOC_SHUTOFF_C_CYC       (`RPOC_SHUTOFF_C_MS * `RPOC_CYC_PER_MS)

`endif

/* inc/rpoc_pkg.sv */
// Purpose: types of the reverse power control
// Assumes: nothing beyond the cfg header
// Notes:   state structs hold all flops of a module
`default_nettype none
package rpoc_pkg;

  typedef enum logic [1:0] {
    RPOC_OFF,
    RPOC_DELAY,
    RPOC_RUN,
    RPOC_LATCHED
  } rpoc_state_t;

  typedef struct packed {
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    rpoc_state_t state;
    logic [2:0]  pin_sync;
    logic        pin_level;
    logic [7:0]  rdata;
  } rpoc_top_st_t;

  typedef struct packed {
    logic [31:0] count;
  } rpoc_tmr_st_t;

endpackage
`default_nettype wire

/* inc/rpoc_tmr_if.sv */
// Purpose: link between the control logic and its interval timer
// Assumes: one clock domain
// Notes:   the timer restarts from zero whenever run drops
`default_nettype none
interface rpoc_tmr_if;
  logic        run;
  logic [31:0] limit;
  logic        done;
  modport ctrl (output run, output limit, input done);
  modport tmr  (input run, input limit, output done);
endinterface
`default_nettype wire

/* rtl/rpoc_timer.sv */
// Purpose: interval counter used for start delay and light-load time
// Assumes: limit is at least one
// Notes:   done is combinational, high on the limit-th cycle of run
`default_nettype none
module rpoc_timer
  import rpoc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  rpoc_tmr_if.tmr   tmr
);

  rpoc_tmr_st_t st_reg;
  rpoc_tmr_st_t st_next;

  // count while run holds, clear when run drops or an interval ends; the
  // restart at the end keeps the light-load interval from inheriting the delay count
  always_comb
  begin
    st_next = st_reg;
    if (!tmr.run || tmr.done)
      st_next.count = 32'h0;
    else
      st_next.count = st_reg.count + 32'h1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // an interruption resets the count, so only an unbroken interval ends
  assign tmr.done = tmr.run && (st_reg.count >= tmr.limit - 32'h1);

endmodule
`default_nettype wire

/* rtl/rpoc_top.sv */
// Purpose: reverse power output enable, start delay, light-load latch-off and status pin
// Assumes: register port is the internal side of the serial register interface
// Notes:   analog settings leave as plain select outputs
//          request pin passes a three-flop filter that resets to inactive
`default_nettype none
`include "rpoc_cfg.svh"

module rpoc_top
  import rpoc_pkg::*;
#(
  parameter int unsigned START_DLY_A_CYC = `RPOC_START_DLY_A_CYC,
  parameter int unsigned START_DLY_B_CYC = `RPOC_START_DLY_B_CYC,
  parameter int unsigned START_DLY_C_CYC = `RPOC_START_DLY_C_CYC,
  parameter int unsigned SHUTOFF_A_CYC   = `RPOC_SHUTOFF_A_CYC,
  parameter int unsigned SHUTOFF_B_CYC   = `RPOC_SHUTOFF_B_CYC,
  parameter int unsigned SHUTOFF_C_CYC   = `RPOC_SHUTOFF_C_CYC
)
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_reverse_request_pin,
  input  wire logic       i_register_request_bypass,
  input  wire logic       i_input_isolation_mode,
  input  wire logic       i_reverse_regulator_fault_ignore,
  input  wire logic       i_regulator_fault,
  input  wire logic       i_input_fault,
  input  wire logic       i_battery_cutoff_reached,
  input  wire logic       i_light_load,
  output logic            o_reverse_run,
  output logic            o_reverse_latched,
  output logic            o_reverse_softstart_select,
  output logic      [2:0] o_battery_cutoff_select,
  output logic      [1:0] o_cable_drop_compensation,
  output logic            o_charge_status_pin_out,
  output logic            o_charge_status_pin_oe
);

  // every flop of this module lives in st_reg
  rpoc_top_st_t st_reg;
  rpoc_top_st_t st_next;
  rpoc_tmr_if   tmr_if ();

  // combinational helpers: all come from registered state or same-clock inputs
  logic        pin_active;
  logic        request;
  logic        stop_fault;
  logic [1:0]  dly_code;
  logic [1:0]  off_code;
  logic        shutoff_armed;
  // interval limits in clock cycles, sized to the timer
  logic [31:0] dly_limit;
  logic [31:0] off_limit;

  // one timer serves both waits: the start delay ends where the light-load
  // interval may begin, so the two never need counting at the same time
  rpoc_timer u_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .tmr       (tmr_if.tmr)
  );

  // request path from registers, synchronised pin and isolation mode
  // the pin is only seen through its filter, so a glitch shorter than two clocks
  // never reaches the sequencer; allow bit and isolation veto the request outright
  always_comb
  begin
    pin_active = st_reg.ctrl_one[`RPOC_B_PIN_POLARITY] ? st_reg.pin_level
                                                       : !st_reg.pin_level;
    request    = st_reg.ctrl_one[`RPOC_B_MASTER_ALLOW]
                 && !i_input_isolation_mode
                 && (st_reg.ctrl_one[`RPOC_B_PIN_BYPASS] ? i_register_request_bypass
                                                         : pin_active);
    // input fault and battery cutoff stop the output whatever the ignore bit says
    stop_fault = (i_regulator_fault && !i_reverse_regulator_fault_ignore)
                 || i_input_fault || i_battery_cutoff_reached;
    dly_code   = st_reg.ctrl_two[`RPOC_B_START_DLY_HI:`RPOC_B_START_DLY_LO];
    off_code   = st_reg.ctrl_one[`RPOC_B_SHUTOFF_HI:`RPOC_B_SHUTOFF_LO];
    // a cleared enable bit or a zero time code both disarm the light-load latch
    shutoff_armed = st_reg.ctrl_one[`RPOC_B_SHUTOFF_EN] && (off_code != 2'h0);
  end

  // interval selection; the same timer serves both waits
  // code 00 never needs a table entry: a zero delay skips the wait state and a
  // zero shutoff code disarms the timer, so the default arm only stands for 11
  always_comb
  begin
    case (dly_code)
      2'h1:    dly_limit = 32'(START_DLY_A_CYC);
      2'h2:    dly_limit = 32'(START_DLY_B_CYC);
      default: dly_limit = 32'(START_DLY_C_CYC);
    endcase
    case (off_code)
      2'h1:    off_limit = 32'(SHUTOFF_A_CYC);
      2'h2:    off_limit = 32'(SHUTOFF_B_CYC);
      default: off_limit = 32'(SHUTOFF_C_CYC);
    endcase
  end

  // the timer runs in delay only while the request holds, in run only under light load
  assign tmr_if.run   = (st_reg.state == RPOC_DELAY && request)
                        || (st_reg.state == RPOC_RUN && shutoff_armed && i_light_load);
  // the limit follows the state, so entering run selects the shutoff time
  assign tmr_if.limit = (st_reg.state == RPOC_DELAY) ? dly_limit : off_limit;

  // next state: register writes, pin filter, enable sequencing, read data
  always_comb
  begin
    st_next = st_reg;
    // pin filter: level changes once the second and third stage agree
    st_next.pin_sync = {st_reg.pin_sync[1:0], i_reverse_request_pin};
    if (st_reg.pin_sync[1] == st_reg.pin_sync[2])
      st_next.pin_level = st_reg.pin_sync[2];
    // a write lands at the strobe edge; a read in the same cycle returns the old value
    if (i_reg_wr && i_reg_addr == `RPOC_OFS_CTRL_ONE)
      st_next.ctrl_one = i_reg_wdata & `RPOC_MASK_CTRL_ONE;
    if (i_reg_wr && i_reg_addr == `RPOC_OFS_CTRL_TWO)
      st_next.ctrl_two = i_reg_wdata;
    // read data is registered and holds until the next read strobe
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `RPOC_OFS_CTRL_ONE: st_next.rdata = st_reg.ctrl_one;
        `RPOC_OFS_CTRL_TWO: st_next.rdata = st_reg.ctrl_two;
        default:            st_next.rdata = 8'h00;
      endcase
    end
    // a fault or a withdrawn request always ends at off, never at latched, so the
    // latch is kept for the light-load case alone; off refuses to leave while a
    // stop fault stands, which keeps the delay from counting through a fault
    case (st_reg.state)
      RPOC_OFF:
      begin
        // a zero delay code skips the wait state altogether
        if (request && !stop_fault)
          st_next.state = (dly_code == 2'h0) ? RPOC_RUN : RPOC_DELAY;
      end
      RPOC_DELAY:
      begin
        // any break in the request or a fault throws the count away
        if (!request || stop_fault)
          st_next.state = RPOC_OFF;
        else if (tmr_if.done)
          st_next.state = RPOC_RUN;
      end
      RPOC_RUN:
      begin
        // a fault or a withdrawal wins over an expiring light-load interval
        if (!request || stop_fault)
          st_next.state = RPOC_OFF;
        else if (tmr_if.done)
          st_next.state = RPOC_LATCHED;
      end
      RPOC_LATCHED:
      begin
        // stays off until the request is withdrawn
        // dropping the request through pin, bypass input, allow bit or isolation mode is the only way out
        if (!request)
          st_next.state = RPOC_OFF;
      end
      // unreachable encodings fall back to off, the safe state
      default: st_next.state = RPOC_OFF;
    endcase
  end

  // all state in one register; the pin filter starts at the idle level of
  // the default active-low pin, so leaving reset never looks like a request
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_reg           <= '0;
      st_reg.ctrl_one  <= `RPOC_RST_CTRL_ONE;
      st_reg.ctrl_two  <= `RPOC_RST_CTRL_TWO;
      st_reg.state     <= RPOC_OFF;
      st_reg.pin_sync  <= `RPOC_RST_PIN_SYNC;
      st_reg.pin_level <= `RPOC_RST_PIN_LEVEL;
    end
    else
      st_reg <= st_next;
  end

  // outputs: every data output comes straight from st_reg, so none glitches
  // while the next state is still being worked out
  assign o_reg_rdata                = st_reg.rdata;
  assign o_reverse_run              = (st_reg.state == RPOC_RUN);
  assign o_reverse_latched          = (st_reg.state == RPOC_LATCHED);
  // analog selections pass straight through to the converter
  assign o_reverse_softstart_select = st_reg.ctrl_one[`RPOC_B_SOFTSTART];
  assign o_battery_cutoff_select    =
    st_reg.ctrl_two[`RPOC_B_CUTOFF_HI:`RPOC_B_CUTOFF_LO];
  assign o_cable_drop_compensation  =
    st_reg.ctrl_two[`RPOC_B_CABLE_HI:`RPOC_B_CABLE_LO];
  // open drain: only ever pulls low, otherwise released; the pin never drives
  // high itself, so with indication off whatever shares the line owns it
  assign o_charge_status_pin_out    = 1'b0;
  assign o_charge_status_pin_oe     = st_reg.ctrl_two[`RPOC_B_STATUS_IND]
                                      && (st_reg.state == RPOC_RUN);

endmodule
`default_nettype wire

/* verif/rpoc_host_model.sv */
// Purpose: host side of the request pin
// Assumes: host knows the polarity it programmed
// Notes:   pin level follows request and polarity at once
`default_nettype none
module rpoc_host_model
(
  input  wire logic i_request,
  input  wire logic i_polarity,
  output logic      o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // active high when polarity set, else active low; host drops and reasserts via i_request
  assign o_pin = i_polarity ? i_request : ~i_request;
endmodule
`default_nettype wire

/* verif/rpoc_top_properties.sv */
// Purpose: port properties of the reverse power control
// Assumes: one clock, async active-low reset
// Notes:   register contents are not visible here
`default_nettype none
module rpoc_top_properties
(
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_input_isolation_mode,
  input wire logic       i_reverse_regulator_fault_ignore,
  input wire logic       i_regulator_fault,
  input wire logic       i_input_fault,
  input wire logic       i_battery_cutoff_reached,
  input wire logic       i_light_load,
  input wire logic       o_reverse_run,
  input wire logic       o_reverse_latched,
  input wire logic       o_charge_status_pin_out,
  input wire logic       o_charge_status_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // open drain: only the enable may move
  a_status_data_low:
    assert property (o_charge_status_pin_out == 1'b0) else $error("status data not low");
  a_status_when_run:
    assert property (o_charge_status_pin_oe |-> o_reverse_run) else $error("pulled while off");
  a_run_latch_apart:
    assert property (!(o_reverse_run && o_reverse_latched)) else $error("run while latched");
  // shortest shutoff is far above eight cycles
  a_latch_after_load:
    assert property ($rose(o_reverse_latched) |-> $past(i_light_load) && $past(i_light_load, 8))
      else $error("latched without light load");
  a_reg_fault_stop:
    assert property (o_reverse_run && i_regulator_fault && !i_reverse_regulator_fault_ignore
      |=> !o_reverse_run) else $error("fault did not stop run");
  a_stop_fault_off:
    assert property (o_reverse_run && (i_input_fault || i_battery_cutoff_reached)
      |=> !o_reverse_run && !o_charge_status_pin_oe) else $error("stop fault ignored");
  a_isolated_no_start:
    assert property ($rose(o_reverse_run) |-> !$past(i_input_isolation_mode))
      else $error("started while isolated");
  a_reserved_bit_zero:
    assert property (i_reg_rd && i_reg_addr == 8'h0e |=> !o_reg_rdata[4])
      else $error("reserved bit reads one");
  c_run_start: cover property ($rose(o_reverse_run));
  c_latch_off: cover property ($rose(o_reverse_latched));
  c_status_pull: cover property ($rose(o_charge_status_pin_oe));
endmodule
bind rpoc_top rpoc_top_properties rpoc_top_properties_i (.i_clk, .i_reset_n, .i_reg_addr,
  .i_reg_rd, .o_reg_rdata, .i_input_isolation_mode, .i_reverse_regulator_fault_ignore,
  .i_regulator_fault, .i_input_fault, .i_battery_cutoff_reached, .i_light_load,
  .o_reverse_run, .o_reverse_latched, .o_charge_status_pin_out, .o_charge_status_pin_oe);
`default_nettype wire

/* verif/reverse_power_output_control_tb.sv */
// Purpose: self-checking bench of the reverse power control
// Assumes: delay counts shortened to 10/20/30, shutoff to 40/60/80
// Notes:   inputs move on the falling edge only
`default_nettype none
module reverse_power_output_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, req = 1'b0, pol = 1'b0;
  logic       byp = 1'b0, iso = 1'b0, ign = 1'b0, rflt = 1'b0, iflt = 1'b0, cut = 1'b0;
  logic       load = 1'b0, run, latched, ss, st_out, st_oe, pin;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] cutsel;
  logic [1:0] cable;
  int         fails = 0, cmp_count = 0;

  always #20 clk = ~clk;

  rpoc_host_model rpoc_host_model_i (.i_request(req), .i_polarity(pol), .o_pin(pin));
  rpoc_top #(.START_DLY_A_CYC(10), .START_DLY_B_CYC(20), .START_DLY_C_CYC(30),
    .SHUTOFF_A_CYC(40), .SHUTOFF_B_CYC(60), .SHUTOFF_C_CYC(80)) rpoc_top_i (
    .i_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_reverse_request_pin(pin),
    .i_register_request_bypass(byp), .i_input_isolation_mode(iso),
    .i_reverse_regulator_fault_ignore(ign), .i_regulator_fault(rflt), .i_input_fault(iflt),
    .i_battery_cutoff_reached(cut), .i_light_load(load), .o_reverse_run(run),
    .o_reverse_latched(latched), .o_reverse_softstart_select(ss),
    .o_battery_cutoff_select(cutsel), .o_cable_drop_compensation(cable),
    .o_charge_status_pin_out(st_out), .o_charge_status_pin_oe(st_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // idle cycle after the strobe so two writes never abut
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(rdata, e);
    cyc(1);
  endtask
  // {status pulled, latched, running} after n cycles
  task automatic see(input int n, input logic [2:0] e);
    cyc(n);
    chk({5'h00, st_oe, latched, run}, {5'h00, e});
  endtask

  task automatic t_regs;
    rd_chk(8'h0e, 8'had);
    rd_chk(8'h0f, 8'h43);
    rd_chk(8'h10, 8'h00);
    chk({2'h0, ss, cutsel, cable}, 8'h28);
    chk({7'h00, st_out}, 8'h00);
    wr_reg(8'h0e, 8'hff);
    rd_chk(8'h0e, 8'hef);
    wr_reg(8'h0e, 8'hcf);
    chk({7'h00, ss}, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      wr_reg(8'h0f, {k[2:0], 1'b0, k[1:0], 2'h0});
      chk({3'h0, cutsel, cable}, {3'h0, k[2:0], k[1:0]});
    end
    $display("registers done");
  endtask
  task automatic t_enable;
    wr_reg(8'h0f, 8'h10);
    wr_reg(8'h0e, 8'h40);
    byp = 1'b1;
    see(6, 3'h0);
    iso = 1'b1;
    wr_reg(8'h0e, 8'hc0);
    see(6, 3'h0);
    iso = 1'b0;
    see(3, 3'h5);
    req = 1'b1;
    byp = 1'b0;
    see(8, 3'h0);
    wr_reg(8'h0e, 8'h82);
    see(8, 3'h0);
    pol = 1'b1;
    see(8, 3'h5);
    $display("enable done");
  endtask
  task automatic t_stops;
    iflt = 1'b1;
    see(2, 3'h0);
    iflt = 1'b0;
    see(3, 3'h5);
    cut = 1'b1;
    see(2, 3'h0);
    cut = 1'b0;
    wr_reg(8'h0f, 8'h00);
    see(3, 3'h1);
    ign = 1'b1;
    rflt = 1'b1;
    see(4, 3'h1);
    ign = 1'b0;
    see(2, 3'h0);
    rflt = 1'b0;
    $display("stops done");
  endtask
  task automatic t_delay;
    wr_reg(8'h0e, 8'hc0);
    for (int k = 1; k < 4; k++)
    begin
      wr_reg(8'h0f, {6'h00, k[1:0]});
      byp = 1'b1;
      see(10 * k - 1, 3'h0);
      see(3, 3'h1);
      byp = 1'b0;
      cyc(2);
    end
    byp = 1'b1;
    cyc(20);
    byp = 1'b0;
    cyc(1);
    byp = 1'b1;
    see(28, 3'h0);
    see(4, 3'h1);
    byp = 1'b0;
    $display("delay done");
  endtask
  task automatic t_light;
    wr_reg(8'h0f, 8'h10);
    for (int k = 1; k < 4; k++)
    begin
      wr_reg(8'h0e, {4'hc, k[1:0], 2'h1});
      byp = 1'b1;
      load = 1'b1;
      see(16 + 20 * k, 3'h5);
      see(8, 3'h2);
      load = 1'b0;
      see(4, 3'h2);
      byp = 1'b0;
      see(3, 3'h0);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(8'h0e, k == 0 ? 8'hc1 : 8'hcc);
      byp = 1'b1;
      load = 1'b1;
      see(90, 3'h5);
      byp = 1'b0;
      load = 1'b0;
      cyc(2);
    end
    $display("light load done");
  endtask
  // pin restart after latch-off, isolation in run, fault in delay, reset in run
  task automatic t_restart;
    wr_reg(8'h0e, 8'h8b);
    load = 1'b1;
    see(56, 3'h5);
    see(8, 3'h2);
    load = 1'b0;
    req = 1'b0;
    see(8, 3'h0);
    req = 1'b1;
    see(8, 3'h5);
    iso = 1'b1;
    see(2, 3'h0);
    iso = 1'b0;
    see(2, 3'h5);
    wr_reg(8'h0f, 8'h11);
    wr_reg(8'h0e, 8'h0b);
    see(2, 3'h0);
    wr_reg(8'h0e, 8'h8b);
    rflt = 1'b1;
    see(12, 3'h0);
    rflt = 1'b0;
    see(8, 3'h0);
    see(4, 3'h5);
    rst_n = 1'b0;
    see(2, 3'h0);
    chk(rdata, 8'h00);
    chk({7'h00, ss}, 8'h01);
    rst_n = 1'b1;
    rd_chk(8'h0e, 8'had);
    pol = 1'b0;
    see(30, 3'h0);
    see(10, 3'h1);
    $display("restart done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    cyc(10);
    rst_n = 1'b1;
    t_regs();
    t_enable();
    t_stops();
    t_delay();
    t_light();
    t_restart();
    finish_test();
  end
  // run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
